// >>> src/sar_adc_pkg.sv
package sar_adc_pkg;

    localparam int unsigned RESULT_W = 10;
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 32;

    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_CONTROL = 8'h93;
    localparam logic [7:0] IDX_TIMING = 8'h94;
    localparam logic [7:0] IDX_PIN_ANALOG = 8'h95;
    localparam logic [7:0] IDX_RESULT_LOW = 8'h96;
    localparam logic [7:0] IDX_RESULT_HIGH = 8'h97;

    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] TIMING_RST = 8'h00;
    localparam logic [7:0] PIN_ANALOG_RST = 8'h00;
    localparam logic [9:0] RESULT_RST = 10'h000;

    localparam int unsigned CTL_ON_BIT = 7;
    localparam int unsigned CTL_FLAG_BIT = 6;
    localparam int unsigned CTL_EC_BIT = 5;
    localparam int unsigned CTL_SCH_LSB = 1;
    localparam int unsigned CTL_GO_BIT = 0;
    localparam int unsigned TIM_DIV_LSB = 5;
    localparam int unsigned TIM_TS_LSB = 0;
    localparam int unsigned RES_LOW_BITS = 2;

    localparam int unsigned SAMPLE_MIN = 2;
    localparam int unsigned SAMPLE_MAX = 15;
    localparam int unsigned CONV_PERIODS = 12;

    // software should keep one converter period at or above this time
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned TAD_MIN_NS = 1000;
    localparam int unsigned TAD_MIN_CYCLES =
        (TAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        return {idx, 2'b00};
    endfunction

    function automatic logic [5:0] tad_cycles(input logic [2:0] code);
        case (code)
            3'h0: return 6'h02;
            3'h1: return 6'h04;
            3'h2: return 6'h06;
            3'h3: return 6'h08;
            3'h4: return 6'h0c;
            3'h5: return 6'h10;
            3'h6: return 6'h18;
            default: return 6'h20;
        endcase
    endfunction

    // bit 8 is the internal supply-derived reference
    function automatic logic [8:0] mux_onehot(input logic [3:0] sel);
        if (sel[3]) begin
            return 9'h100;
        end
        return 9'h001 << sel[2:0];
    endfunction

endpackage

// >>> src/conv_clock_gen.sv
`timescale 1ns/100ps
`default_nettype none

module conv_clock_gen
    import sar_adc_pkg::*;
#(
    parameter int unsigned CNT_W = 6
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_run,
    input wire logic [2:0] i_div_code,
    output logic o_tick
);

    if (CNT_W < 6) begin : g_bad_width
        $error("conv_clock_gen: CNT_W too small for a 32-cycle period");
    end

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] period_last;

    assign period_last = CNT_W'(tad_cycles(i_div_code)) - CNT_W'(1);

    // the divider restarts with every run so the first period is whole
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count <= '0;
        end else if (!i_run || count >= period_last) begin
            count <= '0;
        end else begin
            count <= count + CNT_W'(1);
        end
    end

    assign o_tick = i_run && (count >= period_last);

endmodule

`default_nettype wire

// >>> src/sar_core.sv
`timescale 1ns/100ps
`default_nettype none

module sar_core
    import sar_adc_pkg::*;
#(
    parameter int unsigned BITS = RESULT_W
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_run,
    input wire logic i_tick,
    input wire logic [3:0] i_sample_field,
    input wire logic i_comp,
    output logic o_sampling,
    output logic [BITS-1:0] o_dac,
    output logic o_done
);

    if (BITS < 2 || BITS > CONV_PERIODS - 2) begin : g_bad_bits
        $error("sar_core: BITS does not fit the conversion budget");
    end

    typedef enum logic [2:0] {
        ST_IDLE, ST_SAMPLE, ST_SETUP, ST_BITS, ST_FINISH
    } sar_state_t;

    function automatic logic [3:0] sample_ticks(input logic [3:0] f);
        logic [4:0] sum;
        sum = {1'b0, f} + 5'h01;
        if (sum < 5'(SAMPLE_MIN)) begin
            return 4'(SAMPLE_MIN);
        end
        if (sum > 5'(SAMPLE_MAX)) begin
            return 4'(SAMPLE_MAX);
        end
        return sum[3:0];
    endfunction

    sar_state_t state;
    sar_state_t next_state;
    logic [3:0] sample_cnt;
    logic [BITS-1:0] trial;
    logic [3:0] conv_ticks;
    logic sample_last;

    assign sample_last = i_tick &&
        (sample_cnt == sample_ticks(i_sample_field) - 4'h1);

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: next_state = ST_SAMPLE;
            ST_SAMPLE: if (sample_last) next_state = ST_SETUP;
            ST_SETUP: if (i_tick) next_state = ST_BITS;
            ST_BITS: if (i_tick && trial[0]) next_state = ST_FINISH;
            ST_FINISH: if (i_tick) next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
        if (!i_run) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= ST_IDLE;
            o_sampling <= 1'b0;
        end else begin
            state <= next_state;
            o_sampling <= (next_state == ST_SAMPLE);
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sample_cnt <= 4'h0;
        end else if (state != ST_SAMPLE) begin
            sample_cnt <= 4'h0;
        end else if (i_tick) begin
            sample_cnt <= sample_cnt + 4'h1;
        end
    end

    // msb first; a decision keeps the trial bit when the input is above
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_dac <= '0;
            trial <= '0;
        end else if (state == ST_SAMPLE && sample_last && i_run) begin
            o_dac <= BITS'(1) << (BITS - 1);
            trial <= BITS'(1) << (BITS - 1);
        end else if (state == ST_BITS && i_tick && i_run) begin
            o_dac <= (i_comp ? o_dac : (o_dac & ~trial)) | (trial >> 1);
            trial <= trial >> 1;
        end
    end

    assign o_done = i_run && (state == ST_FINISH) && i_tick;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            conv_ticks <= 4'h0;
        end else if (state == ST_SAMPLE || state == ST_IDLE) begin
            conv_ticks <= 4'h0;
        end else if (i_tick) begin
            conv_ticks <= conv_ticks + 4'h1;
        end
    end

    AST_CONV_PERIODS: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        o_done |-> conv_ticks == 4'(CONV_PERIODS - 1))
        else $error("conversion phase not twelve converter periods");

    AST_SAMPLE_CLAMP: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        (state == ST_SAMPLE && next_state == ST_SETUP) |->
            sample_cnt + 4'h1 >= 4'(SAMPLE_MIN) &&
            sample_cnt + 4'h1 <= 4'(SAMPLE_MAX))
        else $error("sample phase outside its clamp");

endmodule

`default_nettype wire

// >>> src/sar_adc_ctrl.sv
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - converter off: no conversion or comparison; on bit enables the block
// - writing one to start/busy begins a conversion or comparison
// - normal mode: hardware clears start/busy when conversion ends
// - software clearing start/busy mid-conversion aborts it
// - on completion store the 10-bit result and set the flag
// - flag set only by hardware; stays until software writes zero
// - flag set with interrupt enabled raises an interrupt request
// - compare runs only when compare enable and converter on are set
// - compare: flag only when input exceeds stored threshold
// - compare repeats continuously while start/busy stays set
// - compare mode: hardware never clears start/busy
// - channel codes 0-7 pick input n; top bit set picks supply
// - exactly one input is connected to the converter
// - clock select gives 2,4,6,8,12,16,24,32 system clocks per period
// - sample time is field plus one periods, clamped to 2..15
// - conversion lasts twelve periods plus the sample time
// - keeps running in idle; its interrupt wakes the core
// - converter and compare are disabled in power-down
// - result: upper eight bits high register, low two bits low register
// - per-pin register selects digital or analog use of eight pins
module sar_adc_ctrl
    import sar_adc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [DATA_W-1:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [DATA_W-1:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_power_down,
    input wire logic i_conv_irq_enable,
    input wire logic i_comp_above,
    output logic [8:0] o_mux_select,
    output logic o_sampling,
    output logic [RESULT_W-1:0] o_dac_code,
    output logic [7:0] o_pin_analog,
    output logic o_irq,
    output logic o_wake
);

    ////////////////////////////////////////////////////////////////////////
    // register state

    logic converter_on;
    logic conversion_flag;
    logic compare_enable;
    logic [3:0] channel_select;
    logic busy;
    logic [2:0] conv_clock_divider;
    logic [3:0] sample_length;
    logic [7:0] pin_analog_select;
    logic [RESULT_W-1:0] result;

    logic ack;
    logic wr_take;
    logic wr_ctl;
    logic wr_tim;
    logic wr_pin;
    logic wr_lo;
    logic wr_hi;
    logic [7:0] wdata;
    logic [7:0] rd_value;

    logic comp_meta;
    logic comp_sync;
    logic run;
    logic tick;
    logic done;
    logic above;
    logic hw_flag_set;
    logic [RESULT_W-1:0] core_result;

    ////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait state on every access

    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= (i_avs_read || i_avs_write) && !ack;
        end
    end

    assign wdata = i_avs_writedata[7:0];
    assign wr_take = i_avs_write && ack && i_avs_byteenable[0];
    assign wr_ctl = wr_take && (i_avs_address == byte_addr(IDX_CONTROL));
    assign wr_tim = wr_take && (i_avs_address == byte_addr(IDX_TIMING));
    assign wr_pin = wr_take && (i_avs_address == byte_addr(IDX_PIN_ANALOG));
    assign wr_lo = wr_take && (i_avs_address == byte_addr(IDX_RESULT_LOW));
    assign wr_hi = wr_take && (i_avs_address == byte_addr(IDX_RESULT_HIGH));

    always_comb begin
        rd_value = 8'h00;
        case (i_avs_address)
            byte_addr(IDX_CONTROL):
                rd_value = {converter_on, conversion_flag, compare_enable,
                            channel_select, busy};
            byte_addr(IDX_TIMING):
                rd_value = {conv_clock_divider, 1'b0, sample_length};
            byte_addr(IDX_PIN_ANALOG):
                rd_value = pin_analog_select;
            byte_addr(IDX_RESULT_LOW):
                rd_value = {6'h00, result[RES_LOW_BITS-1:0]};
            byte_addr(IDX_RESULT_HIGH):
                rd_value = result[RESULT_W-1:RES_LOW_BITS];
            default:
                rd_value = 8'h00;
        endcase
    end

    // data is latched in the wait cycle so it stands when waitrequest drops
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_avs_readdata <= '0;
        end else if (i_avs_read && !ack) begin
            o_avs_readdata <= {24'h000000, rd_value};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control and timing registers

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            converter_on <= CONTROL_RST[CTL_ON_BIT];
            compare_enable <= CONTROL_RST[CTL_EC_BIT];
            channel_select <= CONTROL_RST[CTL_SCH_LSB +: 4];
        end else if (wr_ctl) begin
            converter_on <= wdata[CTL_ON_BIT];
            compare_enable <= wdata[CTL_EC_BIT];
            channel_select <= wdata[CTL_SCH_LSB +: 4];
        end
    end

    // a software write wins: a one restarts, a zero aborts
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            busy <= CONTROL_RST[CTL_GO_BIT];
        end else if (wr_ctl) begin
            busy <= wdata[CTL_GO_BIT];
        end else if (done && !compare_enable) begin
            busy <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            conv_clock_divider <= TIMING_RST[TIM_DIV_LSB +: 3];
            sample_length <= TIMING_RST[TIM_TS_LSB +: 4];
        end else if (wr_tim) begin
            conv_clock_divider <= wdata[TIM_DIV_LSB +: 3];
            sample_length <= wdata[TIM_TS_LSB +: 4];
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_analog_select <= PIN_ANALOG_RST;
        end else if (wr_pin) begin
            pin_analog_select <= wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // conversion engine

    // the comparator is analog, so it is a foreign input
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            comp_meta <= 1'b0;
            comp_sync <= 1'b0;
        end else begin
            comp_meta <= i_comp_above;
            comp_sync <= comp_meta;
        end
    end

    // idle mode is not an input: the block simply keeps its clock
    assign run = converter_on && busy && !i_power_down;

    conv_clock_gen #(
        .CNT_W(6)
    ) u_clock_gen (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_run(run),
        .i_div_code(conv_clock_divider),
        .o_tick(tick)
    );

    sar_core #(
        .BITS(RESULT_W)
    ) u_core (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_run(run),
        .i_tick(tick),
        .i_sample_field(sample_length),
        .i_comp(comp_sync),
        .o_sampling(o_sampling),
        .o_dac(core_result),
        .o_done(done)
    );

    assign o_dac_code = core_result;

    ////////////////////////////////////////////////////////////////////////
    // result, compare and flag

    // in compare mode the result register is the threshold and is kept
    assign above = core_result > result;
    assign hw_flag_set = done && (!compare_enable || above);

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            result <= RESULT_RST;
        end else if (done && !compare_enable) begin
            result <= core_result;
        end else if (wr_lo) begin
            result[RES_LOW_BITS-1:0] <= wdata[RES_LOW_BITS-1:0];
        end else if (wr_hi) begin
            result[RESULT_W-1:RES_LOW_BITS] <= wdata;
        end
    end

    // writing one is ignored; a set in the clearing cycle wins
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            conversion_flag <= CONTROL_RST[CTL_FLAG_BIT];
        end else if (hw_flag_set) begin
            conversion_flag <= 1'b1;
        end else if (wr_ctl && !wdata[CTL_FLAG_BIT]) begin
            conversion_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs toward the core and the analog side

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_irq <= 1'b0;
            o_wake <= 1'b0;
        end else begin
            o_irq <= conversion_flag && i_conv_irq_enable;
            o_wake <= conversion_flag && i_conv_irq_enable;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_mux_select <= mux_onehot(CONTROL_RST[CTL_SCH_LSB +: 4]);
            o_pin_analog <= PIN_ANALOG_RST;
        end else begin
            o_mux_select <= mux_onehot(channel_select);
            o_pin_analog <= pin_analog_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    AST_OFF_IDLE: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        !converter_on ##1 !converter_on |-> !o_sampling && !done)
        else $error("converter active while switched off");

    AST_START_SAMPLES: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        $rose(run) |=> o_sampling)
        else $error("start did not begin a sample phase");

    AST_AUTO_CLEAR: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        done && !compare_enable && !wr_ctl |=> !busy)
        else $error("busy not cleared after conversion");

    AST_ABORT: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        $fell(busy) |=> !o_sampling ##1 !o_sampling)
        else $error("clearing busy did not abort");

    AST_RESULT_UPDATE: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        done && !compare_enable |=>
            result == $past(core_result) && conversion_flag)
        else $error("result or flag not updated at completion");

    AST_FLAG_STICKY: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        conversion_flag && !(wr_ctl && !wdata[CTL_FLAG_BIT]) |=>
            conversion_flag)
        else $error("flag dropped without a software clear");

    AST_FLAG_HW_ONLY: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        !conversion_flag && !done |=> !conversion_flag)
        else $error("flag set without a completion");

    AST_IRQ: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        conversion_flag && i_conv_irq_enable |=> o_irq && o_wake)
        else $error("interrupt request missing");

    AST_CMP_BELOW: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        done && compare_enable && !above && !conversion_flag |=>
            !conversion_flag)
        else $error("compare flagged a value not above threshold");

    // the core passes through idle for one cycle before it samples again
    AST_CMP_HOLDS: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        done && compare_enable && !wr_ctl |=>
            busy ##1 (o_sampling || !$past(run)))
        else $error("compare mode did not continue");

    AST_BUSY_HW: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        compare_enable && busy && !wr_ctl |=> busy)
        else $error("busy cleared by hardware in compare mode");

    AST_CMP_FLAG: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        done && compare_enable && above |=> conversion_flag)
        else $error("compare above threshold did not flag");

    AST_MUX_FOLLOWS: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        o_mux_select == mux_onehot($past(channel_select)))
        else $error("multiplexer does not follow the channel field");

    AST_ONE_CHANNEL: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        $onehot(o_mux_select))
        else $error("input multiplexer not one-hot");

    AST_POWER_DOWN: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        i_power_down |=> !o_sampling && !done)
        else $error("converter active in power-down");

endmodule

`default_nettype wire

// >>> tb/analog_model.sv
`timescale 1ns/100ps
`default_nettype none
module analog_model
    import sar_adc_pkg::*;
(
    input wire logic [8:0] i_mux_select,
    input wire logic [RESULT_W-1:0] i_dac_code,
    input wire logic [8:0][9:0] i_vin,
    output logic o_comp_above
);
    logic [9:0] v;
    // with no single input connected the comparator sees garbage, not 0
    always_comb begin
        v = ~i_dac_code;
        for (int k = 0; k < 9; k++) begin
            if (i_mux_select == (9'h001 << k)) begin
                v = i_vin[k];
            end
        end
        o_comp_above = (v >= i_dac_code);
    end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
    import sar_adc_pkg::*;
;
    logic i_clk = 0;
    logic i_arst_n = 0;
    logic [ADDR_W-1:0] adr = '0;
    logic rd_s = 0;
    logic wr_s = 0;
    logic [DATA_W-1:0] wdat = '0;
    logic [3:0] be = 4'h1;
    logic pd = 0;
    logic ien = 1;
    logic [8:0][9:0] vin = '0;
    logic comp;
    logic [DATA_W-1:0] rdat;
    logic wait_s, smp, irq, wake;
    int smp_cnt = 0;
    int mark = 0;
    logic [8:0] mux;
    logic [9:0] dac;
    logic [7:0] pin, q;
    int err_count = 0;
    int num_checks = 0;
    int n;
    int per[8] = '{2, 4, 6, 8, 12, 16, 24, 32};

    sar_adc_ctrl dut (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_avs_address(adr), .i_avs_read(rd_s), .i_avs_write(wr_s),
        .i_avs_writedata(wdat), .i_avs_byteenable(be),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wait_s),
        .i_power_down(pd), .i_conv_irq_enable(ien), .i_comp_above(comp),
        .o_mux_select(mux), .o_sampling(smp), .o_dac_code(dac),
        .o_pin_analog(pin), .o_irq(irq), .o_wake(wake));
    analog_model far (.i_mux_select(mux), .i_dac_code(dac), .i_vin(vin),
        .o_comp_above(comp));

    initial forever #50 i_clk = ~i_clk;
    always @(posedge i_clk) if (smp === 1'b1) smp_cnt <= smp_cnt + 1;

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bad();
        err_count++;
        tally_and_finish();
    endtask

    // one idle edge after release so the next request never lands with it
    task automatic bus(input logic w, input logic [7:0] idx,
        input logic [7:0] d);
        int k;
        adr <= {idx, 2'b00};
        wr_s <= w;
        rd_s <= !w;
        wdat <= {24'h0, d};
        for (k = 0; k < 10; k++) begin
            @(posedge i_clk);
            if (wait_s === 1'b0) break;
        end
        q = rdat[7:0];
        if (k == 10) bad();
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] e,
        input string nm);
        bus(1'b0, idx, 8'h00);
        chk(nm, {24'h0, e}, {24'h0, q});
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge i_clk);
    endtask

    task automatic wait_irq();
        for (n = 0; n < 3000; n++) begin
            @(posedge i_clk);
            if (irq === 1'b1) break;
        end
        if (n == 3000) bad();
    endtask

    // a period of 2 clocks is too short for the comparator lag, skip it
    task automatic conv(input logic [2:0] d, input logic [3:0] ts,
        input logic [3:0] ch, input logic [9:0] v);
        int e;
        e = (ts == 0) ? 2 : ((ts == 15) ? 15 : ts + 1);
        e = (e + 12) * per[d];
        vin[ch[3] ? 4'd8 : ch] <= v;
        wr(IDX_TIMING, {d, 1'b0, ts});
        wr(IDX_CONTROL, {3'b100, ch, 1'b1});
        wait_irq();
        chk("conv time", 1, 32'(n >= e - 2 && n <= e + 4));
        chk("mux", ch[3] ? 9'h100 : 9'h001 << ch[2:0], mux);
        rd(IDX_RESULT_HIGH, v[9:2], "res high");
        rd(IDX_RESULT_LOW, {6'h0, v[1:0]}, "res low");
        rd(IDX_CONTROL, {3'b110, ch, 1'b0}, "ctl done");
        wr(IDX_CONTROL, {3'b100, ch, 1'b0});
        idle(1);
        chk("irq clear", 0, irq);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        idle(5);
        i_arst_n <= 1'b1;
        @(posedge i_clk);
        chk("mux reset", 9'h001, mux);
        for (int i = 8'h93; i < 8'h98; i++) rd(8'(i), 8'h00, "reset");
        rd(8'h98, 8'h00, "unmapped");
        wr(IDX_TIMING, 8'hff);
        rd(IDX_TIMING, 8'hef, "timing");
        wr(IDX_PIN_ANALOG, 8'ha5);
        be <= 4'h0;
        wr(IDX_PIN_ANALOG, 8'h00);
        be <= 4'h1;
        chk("pins", 8'ha5, pin);
        for (int c = 0; c < 16; c++) begin
            wr(IDX_CONTROL, {3'b000, 4'(c), 1'b0});
            idle(1);
            chk("chan", (c > 7) ? 9'h100 : 9'h001 << (c % 8), mux);
        end
        for (int d = 1; d < 8; d++) begin
            conv(3'(d), (d == 7) ? 4'hf : 4'(2 * d - 2), 4'(d),
                10'h2d7 - 10'(d * 37));
        end
        conv(3'd4, 4'h1, 4'hb, 10'h155);
        mark = smp_cnt;
        wr(IDX_TIMING, 8'h20);
        wr(IDX_CONTROL, 8'h21);
        idle(200);
        chk("off idle", mark, smp_cnt);
        rd(IDX_CONTROL, 8'h21, "off ctl");
        pd <= 1'b1;
        wr(IDX_CONTROL, 8'h81);
        idle(200);
        bus(1'b0, IDX_CONTROL, 8'h00);
        chk("pd flag", 0, q[6]);
        chk("pd run", mark, smp_cnt);
        wr(IDX_CONTROL, 8'h00);
        pd <= 1'b0;
        wr(IDX_TIMING, 8'hef);
        wr(IDX_CONTROL, 8'h81);
        idle(50);
        chk("sampling", 1, smp);
        wr(IDX_CONTROL, 8'h80);
        idle(2);
        mark = smp_cnt;
        idle(1000);
        chk("abort", mark, smp_cnt);
        rd(IDX_CONTROL, 8'h80, "abort ctl");
        wr(IDX_TIMING, 8'h20);
        wr(IDX_RESULT_HIGH, 8'h40);
        wr(IDX_RESULT_LOW, 8'h00);
        vin[0] <= 10'h100;
        wr(IDX_CONTROL, 8'ha1);
        idle(600);
        rd(IDX_CONTROL, 8'ha1, "cmp equal");
        vin[0] <= 10'h101;
        wait_irq();
        chk("cmp repeat", 1, 32'(n < 200));
        chk("wake", 1, wake);
        rd(IDX_RESULT_HIGH, 8'h40, "threshold");
        rd(IDX_CONTROL, 8'he1, "cmp busy");
        ien <= 1'b0;
        idle(2);
        chk("irq masked", 0, irq);
        ien <= 1'b1;
        wr(IDX_CONTROL, 8'h80);
        // a compare ending in the stopping cycle still flags: clear again
        wr(IDX_CONTROL, 8'h80);
        idle(300);
        rd(IDX_CONTROL, 8'h80, "cmp stop");
        tally_and_finish();
    end
endmodule
`default_nettype wire
